// >>> bench/pfm_monitor_tb.sv
// Self-checking bench of the permanent-fail monitor
`timescale 1ns/1ps
`default_nettype none
`include "pfm_params.svh"
module pfm_monitor_tb;
   import pfm_pkg::*;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   pfm_apb_req_t req = '0;
   pfm_apb_rsp_t rsp;
   pfm_meas_t meas = '0;
   logic tick;
   logic chg_on = 1'b1, dsg_on = 1'b1, osc = 1'b0, mux = 1'b0, fuse = 1'b0;
   pfm_mode_req_t mreq = '0;
   logic [6:0] flags, eflag, pfen = 7'h7f;
   logic off, irq, eoff, fs1, fs2, se;
   pfm_mode_t mode;
   int err_count = 0, checks_done = 0;
   int edly[7], cnt[7];
   logic [31:0] rd;
   always #12.5 clk = ~clk;
   pfm_monitor dut_u (.clk(clk), .rstn(rstn), .apb_req(req), .apb_rsp(rsp),
      .meas(meas), .tick_1s(tick), .charge_switch_on(chg_on),
      .discharge_switch_on(dsg_on), .osc_integrity_err(osc),
      .mux_check_fail(mux), .fuse_pin(fuse), .pf_enable(pfen),
      .mode_req(mreq), .pf_flags(flags), .switches_off(off), .mode(mode),
      .irq(irq));
   pfm_tick_src tick_u (.clk(clk), .rstn(rstn), .tick_1s(tick));
   task automatic check(input string n, input logic [31:0] e,
         input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         err_count++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // Reference model; blocking updates see pre-edge inputs like the design
   always @(posedge clk or negedge rstn) begin
      logic [6:0] c;
      int cur, mx;
      if (!rstn) begin
         eflag = '0;
         eoff = 1'b0;
         fs1 = 1'b0;
         fs2 = 1'b0;
         cnt = '{default: 0};
      end else begin
         cur = $signed(meas.current_ma);
         mx = $signed(meas.cell_max_mv);
         c[0] = mx >= 3700 && (cur >= 50 || cur <= -50) &&
            mx - $signed(meas.cell_min_mv) >= 200;
         c[1] = !chg_on && cur >= 20;
         c[2] = !dsg_on && cur <= -20;
         c[3] = meas.gnd_count >= 16'd100;
         c[4] = fs2;
         c[5] = osc;
         c[6] = mux;
         for (int i = 0; i < 7; i++) begin
            if (!c[i] && (i != 4 || tick)) begin
               cnt[i] = 0;
            end else if (tick) begin
               cnt[i]++;
               if (cnt[i] >= edly[i] && pfen[i]) eflag[i] = 1'b1;
            end
         end
         if (osc && edly[5] == 0) eoff = 1'b1;
         fs2 = fs1;
         fs1 = fuse;
      end
   end
   always @(negedge clk) begin
      if (rstn) begin
         check("imb", 32'(eflag[0]), 32'(flags[0]));
         check("chg", 32'(eflag[1]), 32'(flags[1]));
         check("dsg", 32'(eflag[2]), 32'(flags[2]));
         check("gnd", 32'(eflag[3]), 32'(flags[3]));
         check("fuse", 32'(eflag[4]), 32'(flags[4]));
         check("osc", 32'(eflag[5]), 32'(flags[5]));
         check("mux", 32'(eflag[6]), 32'(flags[6]));
         check("off", {31'h0, eoff}, {31'h0, off});
      end
   end
   task automatic apb(input logic wr, input logic [7:0] a,
         input logic [31:0] d);
      int n;
      @(posedge clk);
      req <= '{1'b1, 1'b0, wr, a, d};
      @(posedge clk);
      req.penable <= 1'b1;
      for (n = 0; n < 16; n++) begin
         @(posedge clk);
         if (rsp.pready === 1'b1) break;
      end
      rd = rsp.prdata;
      se = rsp.pslverr;
      req <= '0;
      if (n == 16) begin
         check("apb wait", 0, 1);
         print_verdict();
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      check("read", e, rd);
   endtask
   task automatic do_reset();
      @(posedge clk);
      rstn <= 1'b0;
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      edly = '{default: 5};
   endtask
   task automatic quiet();
      meas <= '{16'd3000, 16'd3000, 16'h0, 16'h0};
      {chg_on, dsg_on, osc, mux, fuse} <= 5'b11000;
   endtask
   // Values sit on both sides of every threshold
   task automatic rnd();
      int cv[8] = '{-60, -30, -20, -19, 19, 20, 60, 0};
      logic [15:0] mx;
      mx = ($urandom % 3 == 0) ? 16'd3699 : 16'd3700 + 16'($urandom % 400);
      meas <= '{mx, mx - 16'd199 - 16'($urandom % 3),
         16'(cv[$urandom % 8]), 16'd98 + 16'($urandom % 4)};
      {chg_on, dsg_on} <= 2'($urandom);
      {osc, mux, fuse} <= ($urandom % 4 == 0) ? 3'h0 : 3'($urandom);
   endtask
   task automatic mstep(input int f, input pfm_mode_t e);
      @(posedge clk);
      mreq <= pfm_mode_req_t'(7'h40 >> f);
      @(posedge clk);
      mreq <= '0;
      @(negedge clk);
      check("mode", 32'(e), 32'(mode));
   endtask
   pfm_mode_t ma[7] = '{mode_cfg, mode_locked, mode_unlocked, mode_sleep,
      mode_locked, mode_unlocked, mode_full};
   int fa[7] = '{2, 3, 0, 4, 5, 0, 1};
   logic [7:0] ra[9] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14,
      8'h1c, 8'h20, 8'h24};
   logic [31:0] ea[9] = '{32'h0, 32'h00320e74, 32'h006400c8,
      32'hffec0014, 32'h05050505, 32'h00050505, 32'h0, 32'h0,
      32'(mode_full)};
   logic [31:0] dv;
   initial begin
      void'($urandom(90));
      do_reset();
      for (int i = 0; i < 9; i++) rchk(ra[i], ea[i]);
      apb(1'b0, 8'h2a, 32'h0);
      check("slverr", 32'h1, {31'h0, se});
      check("slverr data", 32'h0, rd);
      apb(1'b1, `PFM_OFF_LOCK, 32'h01);
      for (int i = 0; i < 7; i++) mstep(fa[i], ma[i]);
      apb(1'b1, `PFM_OFF_LOCK, 32'hff);
      rchk(`PFM_OFF_LOCK, 32'h07);
      mstep(2, mode_full);
      mstep(6, mode_locked);
      mstep(0, mode_locked);
      rchk(`PFM_OFF_STAT, 32'h80);
      // Out-of-range settings land on their nearest bound
      apb(1'b1, `PFM_OFF_IMB, 32'h0005_2000);
      rchk(`PFM_OFF_IMB, 32'h000a_157c);
      apb(1'b1, `PFM_OFF_THR, 32'h0000_ffff);
      rchk(`PFM_OFF_THR, 32'h0001_0000);
      apb(1'b1, `PFM_OFF_SW, 32'h8000_0001);
      rchk(`PFM_OFF_SW, 32'hec78_000a);
      for (int r = 0; r < 6; r++) begin
         do_reset();
         pfen <= 7'($urandom);
         dv = $urandom & 32'h03030303;
         apb(1'b1, `PFM_OFF_DLY0, dv);
         for (int i = 0; i < 4; i++) edly[i] = dv[8*i+:8];
         dv = $urandom & 32'h00030303;
         apb(1'b1, `PFM_OFF_DLY1, dv);
         for (int i = 0; i < 3; i++) edly[4+i] = dv[8*i+:8];
         apb(1'b1, `PFM_OFF_MASK, 32'h7f);
         // Late enable must still fire a saturated run on the next tick
         for (int k = 0; k < 240; k++) begin
            @(posedge clk);
            if (k == 120) pfen <= 7'h7f;
            if ($urandom % 24 == 0) rnd();
         end
         quiet();
         repeat (4) @(posedge clk);
         rchk(`PFM_OFF_FLAG, {25'h0, eflag});
         @(negedge clk);
         check("irq", {31'h0, |eflag}, {31'h0, irq});
         rchk(`PFM_OFF_STAT, {25'h0, eflag});
         @(negedge clk);
         check("irq", 32'h0, {31'h0, irq});
      end
      print_verdict();
   end
endmodule
`default_nettype wire

// >>> bench/pfm_tick_src.sv
// Timebase model of the measurement side: one-cycle second tick
`timescale 1ns/1ps
`default_nettype none
module pfm_tick_src #(
   parameter int PERIOD = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Timebase
   output logic tick_1s
);
   int cnt_q;
   // Short second so persistence runs fit in a brief simulation
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt_q <= 0;
         tick_1s <= 1'b0;
      end else begin
         cnt_q <= (cnt_q == PERIOD - 1) ? 0 : cnt_q + 1;
         tick_1s <= (cnt_q == PERIOD - 1);
      end
   end
endmodule
`default_nettype wire

// >>> rtl/pfm_lock.sv
// Access mode state machine governed by the lock settings
`timescale 1ns/1ps
`default_nettype none
`include "pfm_params.svh"
module pfm_lock (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Settings and requests
   input wire logic [2:0] settings,
   input wire pfm_pkg::pfm_mode_req_t req,
   // Mode
   output var pfm_pkg::pfm_mode_t mode,
   output logic refused
);
   import pfm_pkg::*;
   pfm_mode_t mode_q, mode_d;

   // Mode taken after reset, configuration exit and deep sleep exit
   function automatic pfm_mode_t rest_mode(input logic [2:0] s);
      if (s[`PFM_BIT_DEFAULT_LOCKED]) begin
         rest_mode = mode_locked;
      end else if (s[`PFM_BIT_FREEZE]) begin
         rest_mode = mode_unlocked;
      end else begin
         rest_mode = mode_full;
      end
   endfunction

   always_comb begin
      mode_d = mode_q;
      refused = 1'b0;
      case (mode_q)
         mode_boot: mode_d = rest_mode(settings);
         mode_locked: begin
            if (req.unlock) begin
               if (settings[`PFM_BIT_PERM]) begin
                  refused = 1'b1;
               end else begin
                  mode_d = mode_unlocked;
               end
            end
         end
         mode_unlocked: begin
            if (req.full) begin
               if (settings[`PFM_BIT_FREEZE]) begin
                  refused = 1'b1;
               end else begin
                  mode_d = mode_full;
               end
            end else if (req.relock) begin
               mode_d = mode_locked;
            end else if (req.sleep_enter) begin
               mode_d = mode_sleep;
            end
         end
         mode_full: begin
            if (req.cfg_enter) begin
               if (settings[`PFM_BIT_FREEZE]) begin
                  refused = 1'b1;
               end else begin
                  mode_d = mode_cfg;
               end
            end else if (req.relock) begin
               mode_d = mode_locked;
            end else if (req.sleep_enter) begin
               mode_d = mode_sleep;
            end
         end
         mode_cfg: begin
            if (req.cfg_exit) begin
               mode_d = rest_mode(settings);
            end
         end
         mode_sleep: begin
            if (req.sleep_exit) begin
               mode_d = rest_mode(settings);
            end
         end
         default: mode_d = mode_boot;
      endcase
   end

   // Reset lands in boot so the settings are read after release
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         mode_q <= mode_boot;
      end else begin
         mode_q <= mode_d;
      end
   end
   assign mode = mode_q;

   a_perm_hold:
   assert property (@(posedge clk) disable iff (!rstn)
      (mode_q == mode_locked && settings[`PFM_BIT_PERM])
      |=> mode_q == mode_locked)
      else $error("Left locked mode under permanent lock");
   a_freeze_cfg:
   assert property (@(posedge clk) disable iff (!rstn)
      (settings[`PFM_BIT_FREEZE] && mode_q != mode_cfg)
      |=> mode_q != mode_cfg)
      else $error("Entered configuration mode while frozen");
   a_freeze_full:
   assert property (@(posedge clk) disable iff (!rstn)
      (settings[`PFM_BIT_FREEZE] && mode_q != mode_full)
      |=> mode_q != mode_full)
      else $error("Entered full access while frozen");
   a_default_locked_default:
   assert property (@(posedge clk) disable iff (!rstn)
      ((mode_q == mode_boot || (mode_q == mode_cfg && req.cfg_exit))
      && settings[`PFM_BIT_DEFAULT_LOCKED]) |=> mode_q == mode_locked)
      else $error("Default-locked device not locked");
endmodule
`default_nettype wire

// >>> rtl/pfm_monitor.sv
// Permanent-fail monitor with register slave and interrupt
`timescale 1ns/1ps
`default_nettype none
`include "pfm_params.svh"
module pfm_monitor (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Register bus
   input wire pfm_pkg::pfm_apb_req_t apb_req,
   output var pfm_pkg::pfm_apb_rsp_t apb_rsp,
   // Measurements and timebase
   input wire pfm_pkg::pfm_meas_t meas,
   input wire logic tick_1s,
   input wire logic charge_switch_on,
   input wire logic discharge_switch_on,
   // Integrity sources
   input wire logic osc_integrity_err,
   input wire logic mux_check_fail,
   input wire logic fuse_pin,
   // Enable mask from configuration
   input wire logic [`PFM_NPF-1:0] pf_enable,
   // Mode requests from the key checker
   input wire pfm_pkg::pfm_mode_req_t mode_req,
   // Results
   output logic [`PFM_NPF-1:0] pf_flags,
   output logic switches_off,
   output var pfm_pkg::pfm_mode_t mode,
   output logic irq
);
   import pfm_pkg::*;
   localparam int NPF = `PFM_NPF;

   // Configuration registers
   logic [7:0] lock_q, lock_d;
   logic [15:0] chk_q, chk_d;
   logic [15:0] mincur_q, mincur_d;
   logic [15:0] imb_q, imb_d;
   logic [15:0] gnd_q, gnd_d;
   logic [15:0] chg_q, chg_d;
   logic [15:0] dsg_q, dsg_d;
   logic [7:0] dly_q [NPF];
   logic [7:0] dly_d [NPF];

   // Status and bus state
   pfm_apb_rsp_t rsp_q, rsp_d;
   logic [7:0] stat_q, stat_d;
   logic [7:0] mask_q, mask_d;
   logic [NPF-1:0] flags_q, flags_d;
   logic [NPF-1:0] cond, hit;
   logic off_q, off_d;
   logic irq_q, irq_d;
   logic fuse_m_q, fuse_s_q;
   logic refused;
   logic [31:0] rdata;

   // Bus phases
   logic [7:0] addr;
   logic setup, access, wr, rd_stat;
   assign addr = apb_req.paddr;
   assign setup = apb_req.psel && !apb_req.penable;
   assign access = apb_req.psel && apb_req.penable && rsp_q.pready;
   assign wr = access && apb_req.pwrite && !rsp_q.pslverr;
   assign rd_stat = access && !apb_req.pwrite && !rsp_q.pslverr
      && addr == `PFM_OFF_STAT;

   function automatic logic mapped(input logic [7:0] a);
      case (a)
         `PFM_OFF_LOCK, `PFM_OFF_IMB, `PFM_OFF_THR, `PFM_OFF_SW,
         `PFM_OFF_DLY0, `PFM_OFF_DLY1, `PFM_OFF_STAT,
         `PFM_OFF_MASK, `PFM_OFF_FLAG, `PFM_OFF_MODE: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   endfunction

   // Settings hold their documented ranges whatever software writes
   function automatic logic [15:0] clamp(input logic [15:0] v,
      input logic [15:0] lo, input logic [15:0] hi);
      if ($signed(v) < $signed(lo)) begin
         clamp = lo;
      end else if ($signed(v) > $signed(hi)) begin
         clamp = hi;
      end else begin
         clamp = v;
      end
   endfunction

   // Read data mux
   always_comb begin
      rdata = 32'h0000_0000;
      case (addr)
         `PFM_OFF_LOCK: rdata = {24'h00_0000, lock_q};
         `PFM_OFF_IMB: rdata = {mincur_q, chk_q};
         `PFM_OFF_THR: rdata = {gnd_q, imb_q};
         `PFM_OFF_SW: rdata = {dsg_q, chg_q};
         `PFM_OFF_DLY0: rdata = {dly_q[3], dly_q[2], dly_q[1], dly_q[0]};
         `PFM_OFF_DLY1: rdata = {8'h00, dly_q[6], dly_q[5], dly_q[4]};
         `PFM_OFF_STAT: rdata = {24'h00_0000, stat_q};
         `PFM_OFF_MASK: rdata = {24'h00_0000, mask_q};
         `PFM_OFF_FLAG: rdata = {25'h000_0000, flags_q};
         `PFM_OFF_MODE: rdata = {29'h0000_0000, mode};
         default: rdata = 32'h0000_0000;
      endcase
   end

   // Slave answers in the first access cycle, no wait states
   always_comb begin
      rsp_d.pready = setup;
      rsp_d.pslverr = setup && !mapped(addr);
      rsp_d.prdata = 32'h0000_0000;
      if (setup && !apb_req.pwrite && mapped(addr)) begin
         rsp_d.prdata = rdata;
      end
   end

   // Register writes
   always_comb begin
      lock_d = lock_q;
      chk_d = chk_q;
      mincur_d = mincur_q;
      imb_d = imb_q;
      gnd_d = gnd_q;
      chg_d = chg_q;
      dsg_d = dsg_q;
      mask_d = mask_q;
      dly_d = dly_q;
      if (wr) begin
         case (addr)
            `PFM_OFF_LOCK: begin
               lock_d = apb_req.pwdata[7:0] & `PFM_LOCK_MASK;
            end
            `PFM_OFF_IMB: begin
               chk_d = clamp(apb_req.pwdata[15:0], 16'h0000, `PFM_MAX_CHK);
               mincur_d = clamp(apb_req.pwdata[31:16], `PFM_MIN_MINCUR,
                  `PFM_MAX_POS);
            end
            `PFM_OFF_THR: begin
               imb_d = clamp(apb_req.pwdata[15:0], 16'h0000, `PFM_MAX_CHK);
               gnd_d = clamp(apb_req.pwdata[31:16], `PFM_MIN_GND,
                  `PFM_MAX_POS);
            end
            `PFM_OFF_SW: begin
               chg_d = clamp(apb_req.pwdata[15:0], `PFM_MIN_CHG,
                  `PFM_MAX_CHG);
               dsg_d = clamp(apb_req.pwdata[31:16], `PFM_MIN_DSG,
                  `PFM_MAX_DSG);
            end
            `PFM_OFF_DLY0: begin
               for (int i = 0; i < 4; i++) begin
                  dly_d[i] = apb_req.pwdata[8*i +: 8];
               end
            end
            `PFM_OFF_DLY1: begin
               for (int i = 4; i < NPF; i++) begin
                  dly_d[i] = apb_req.pwdata[8*(i-4) +: 8];
               end
            end
            `PFM_OFF_MASK: mask_d = apb_req.pwdata[7:0];
            default: mask_d = mask_q;
         endcase
      end
   end

   // Sign-extended operands
   logic signed [16:0] cmax, cmin, cur, acur, diff;
   logic signed [16:0] chk, minc, imbt, chgt, dsgt;
   always_comb begin
      cmax = $signed({meas.cell_max_mv[15], meas.cell_max_mv});
      cmin = $signed({meas.cell_min_mv[15], meas.cell_min_mv});
      cur = $signed({meas.current_ma[15], meas.current_ma});
      acur = (cur < 0) ? -cur : cur;
      diff = cmax - cmin;
      chk = $signed({chk_q[15], chk_q});
      minc = $signed({mincur_q[15], mincur_q});
      imbt = $signed({imb_q[15], imb_q});
      chgt = $signed({chg_q[15], chg_q});
      dsgt = $signed({dsg_q[15], dsg_q});
   end

   // Fault conditions
   always_comb begin
      cond[0] = (cmax >= chk)
         && (acur >= minc)
         && (diff >= imbt);
      cond[1] = !charge_switch_on && (cur >= chgt);
      cond[2] = !discharge_switch_on && (cur <= dsgt);
      cond[3] = meas.gnd_count >= gnd_q;
      cond[4] = fuse_s_q;
      cond[5] = osc_integrity_err;
      cond[6] = mux_check_fail;
   end

   // Fuse input is sampled only on the tick, so a short glitch is ignored
   genvar g;
   generate
      for (g = 0; g < NPF; g++) begin : g_pf
         pfm_persist #(
            .TICK_ONLY(g == `PFM_IDX_FUSE)
         ) u_persist (
            .clk(clk),
            .rstn(rstn),
            .tick(tick_1s),
            .cond(cond[g]),
            .delay(dly_q[g]),
            .hit(hit[g])
         );
      end
   endgenerate

   pfm_lock u_lock (
      .clk(clk),
      .rstn(rstn),
      .settings(lock_q[2:0]),
      .req(mode_req),
      .mode(mode),
      .refused(refused)
   );

   // Flags, forced switch-off, status and interrupt
   always_comb begin
      flags_d = flags_q | (hit & pf_enable);
      off_d = off_q;
      if (osc_integrity_err && dly_q[`PFM_IDX_OSC] == 8'h00) begin
         off_d = 1'b1;
      end
      stat_d = stat_q;
      // Clear only what was returned, so a fresh event survives the read
      if (rd_stat) begin
         stat_d = stat_q & ~rsp_q.prdata[7:0];
      end
      stat_d = stat_d | {refused, flags_d & ~flags_q};
      irq_d = |(stat_d & mask_d);
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         lock_q <= `PFM_RST_LOCK;
         chk_q <= `PFM_RST_CHK;
         mincur_q <= `PFM_RST_MINCUR;
         imb_q <= `PFM_RST_IMB;
         gnd_q <= `PFM_RST_GND;
         chg_q <= `PFM_RST_CHG;
         dsg_q <= `PFM_RST_DSG;
         for (int i = 0; i < NPF; i++) begin
            dly_q[i] <= `PFM_RST_DLY;
         end
         mask_q <= 8'h00;
         stat_q <= 8'h00;
         flags_q <= '0;
         off_q <= 1'b0;
         irq_q <= 1'b0;
         rsp_q <= '0;
         fuse_m_q <= 1'b0;
         fuse_s_q <= 1'b0;
      end else begin
         lock_q <= lock_d;
         chk_q <= chk_d;
         mincur_q <= mincur_d;
         imb_q <= imb_d;
         gnd_q <= gnd_d;
         chg_q <= chg_d;
         dsg_q <= dsg_d;
         dly_q <= dly_d;
         mask_q <= mask_d;
         stat_q <= stat_d;
         flags_q <= flags_d;
         off_q <= off_d;
         irq_q <= irq_d;
         rsp_q <= rsp_d;
         fuse_m_q <= fuse_pin;
         fuse_s_q <= fuse_m_q;
      end
   end

   assign apb_rsp = rsp_q;
   assign pf_flags = flags_q;
   assign switches_off = off_q;
   assign irq = irq_q;

   a_imb_volt_gate:
   assert property (@(posedge clk) disable iff (!rstn)
      $rose(flags_q[0]) |-> $past(cmax >= chk))
      else $error("Imbalance flag set below check voltage");
   a_imb_cur_gate:
   assert property (@(posedge clk) disable iff (!rstn)
      $rose(flags_q[0]) |-> $past(acur >= minc))
      else $error("Imbalance flag set below minimum current");
   a_imb_delta:
   assert property (@(posedge clk) disable iff (!rstn)
      $rose(flags_q[0]) |-> $past(tick_1s && diff >= imbt))
      else $error("Imbalance flag without delta on a tick");
   a_chg_stuck:
   assert property (@(posedge clk) disable iff (!rstn)
      $rose(flags_q[1]) |-> $past(!charge_switch_on && cur >= chgt))
      else $error("Charge switch flag without cause");
   a_dsg_stuck:
   assert property (@(posedge clk) disable iff (!rstn)
      $rose(flags_q[2]) |-> $past(!discharge_switch_on && cur <= dsgt))
      else $error("Discharge switch flag without cause");
   a_gnd_count:
   assert property (@(posedge clk) disable iff (!rstn)
      $rose(flags_q[3]) |-> $past(tick_1s && meas.gnd_count >= gnd_q))
      else $error("Ground flag without count over threshold");
   a_fuse_tick:
   assert property (@(posedge clk) disable iff (!rstn)
      $rose(flags_q[4]) |-> $past(tick_1s && fuse_s_q))
      else $error("Second-level flag set off a tick");
   a_osc_flag:
   assert property (@(posedge clk) disable iff (!rstn)
      $rose(flags_q[5]) |-> $past(tick_1s && osc_integrity_err))
      else $error("Oscillator flag without error on a tick");
   a_osc_force_off:
   assert property (@(posedge clk) disable iff (!rstn)
      (osc_integrity_err && dly_q[`PFM_IDX_OSC] == 8'h00)
      |=> switches_off [*2])
      else $error("Switches not forced off on oscillator failure");
   a_mux_flag:
   assert property (@(posedge clk) disable iff (!rstn)
      $rose(flags_q[6]) |-> $past(tick_1s && mux_check_fail))
      else $error("Mux flag without failing check on a tick");
   a_lock_reserved:
   assert property (@(posedge clk) disable iff (!rstn)
      wr && addr == `PFM_OFF_LOCK |=> lock_q[7:3] == 5'h00
      && lock_q[2:0] == $past(apb_req.pwdata[2:0]))
      else $error("Lock byte reserved bits not zero");

   c_imb_fail: cover property (@(posedge clk) disable iff (!rstn)
      $rose(flags_q[0]));
   c_force_off: cover property (@(posedge clk) disable iff (!rstn)
      $rose(off_q));
   c_irq_clear: cover property (@(posedge clk) disable iff (!rstn)
      irq_q ##1 rd_stat ##1 !irq_q);
endmodule
`default_nettype wire

// >>> rtl/pfm_params.svh
// Offsets, reset values and field positions of the permanent-fail monitor
`ifndef PFM_PARAMS_SVH
`define PFM_PARAMS_SVH
`define PFM_NPF 7
`define PFM_OFF_LOCK 8'h00
`define PFM_OFF_IMB 8'h04
`define PFM_OFF_THR 8'h08
`define PFM_OFF_SW 8'h0c
`define PFM_OFF_DLY0 8'h10
`define PFM_OFF_DLY1 8'h14
`define PFM_OFF_STAT 8'h18
`define PFM_OFF_MASK 8'h1c
`define PFM_OFF_FLAG 8'h20
`define PFM_OFF_MODE 8'h24
`define PFM_RST_LOCK 8'h00
`define PFM_LOCK_MASK 8'h07
`define PFM_BIT_PERM 2
`define PFM_BIT_FREEZE 1
`define PFM_BIT_DEFAULT_LOCKED 0
`define PFM_RST_CHK 16'h0e74
`define PFM_MAX_CHK 16'h157c
`define PFM_RST_MINCUR 16'h0032
`define PFM_MIN_MINCUR 16'h000a
`define PFM_MAX_POS 16'h7fff
`define PFM_RST_IMB 16'h00c8
`define PFM_RST_CHG 16'h0014
`define PFM_MIN_CHG 16'h000a
`define PFM_MAX_CHG 16'h1388
`define PFM_RST_DSG 16'hffec
`define PFM_MIN_DSG 16'hec78
`define PFM_MAX_DSG 16'hfff6
`define PFM_RST_GND 16'h0064
`define PFM_MIN_GND 16'h0001
`define PFM_RST_DLY 8'h05
`define PFM_IDX_FUSE 4
`define PFM_IDX_OSC 5
`endif

// >>> rtl/pfm_persist.sv
// Seconds persistence counter for one fault condition
`timescale 1ns/1ps
`default_nettype none
module pfm_persist #(
   parameter bit TICK_ONLY = 1'b0
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Fault condition
   input wire logic tick,
   input wire logic cond,
   input wire logic [7:0] delay,
   // Result
   output logic hit
);
   logic [7:0] cnt_q, cnt_d;

   always_comb begin
      cnt_d = cnt_q;
      hit = 1'b0;
      if (!cond && (!TICK_ONLY || tick)) begin
         cnt_d = 8'h00;
      end else if (tick && cond) begin
         if ({1'b0, cnt_q} + 9'h001 >= {1'b0, delay}) begin
            hit = 1'b1;
         end else begin
            cnt_d = cnt_q + 8'h01;
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt_q <= 8'h00;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   a_run_clear:
   assert property (@(posedge clk) disable iff (!rstn)
      (!cond && (!TICK_ONLY || tick)) |=> cnt_q == 8'h00)
      else $error("Count kept after fault dropped");
   a_zero_delay:
   assert property (@(posedge clk) disable iff (!rstn)
      (tick && cond && delay == 8'h00) |-> hit)
      else $error("Zero delay did not fire on first tick");
endmodule
`default_nettype wire

// >>> rtl/pfm_pkg.sv
// Types shared by the permanent-fail monitor
`default_nettype none
package pfm_pkg;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } pfm_apb_req_t;
   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } pfm_apb_rsp_t;
   typedef struct packed {
      logic [15:0] cell_max_mv;
      logic [15:0] cell_min_mv;
      logic [15:0] current_ma;
      logic [15:0] gnd_count;
   } pfm_meas_t;
   typedef struct packed {
      logic unlock;
      logic full;
      logic cfg_enter;
      logic cfg_exit;
      logic sleep_enter;
      logic sleep_exit;
      logic relock;
   } pfm_mode_req_t;
   typedef enum logic [2:0] {
      mode_boot, mode_locked, mode_unlocked, mode_full, mode_cfg, mode_sleep
   } pfm_mode_t;
endpackage
`default_nettype wire
